/* hw/duargc_pkg.sv */
/*
 package of the global configuration and status block of a dual uart:
 register offsets, field positions, reset values, timing counts, carriers.
 assumes a 7-bit host address space and two channels.
*/
package duargc_pkg;
   localparam int CLK_MHZ = 100;
   localparam int NUM_CH  = 2;
   // host address map (7-bit)
   localparam logic [6:0] LEGACY_TOP    = 7'h10;
   localparam logic [6:0] CMD_A_ADDR    = 7'h02;
   localparam logic [6:0] CMD_B_ADDR    = 7'h0A;
   localparam logic [6:0] GCFG_ADDR     = 7'h70;
   localparam logic [6:0] TREV_ADDR     = 7'h71;
   localparam logic [6:0] EOPS_ADDR     = 7'h72;
   localparam logic [6:0] SFST_A_ADDR   = 7'h73;
   localparam logic [6:0] SEST_A_ADDR   = 7'h75;
   localparam logic [6:0] STC_ADDR      = 7'h77;
   localparam logic [6:0] ISTAT_A_ADDR  = 7'h78;
   localparam logic [6:0] FEAT_A_ADDR   = 7'h7A;
   localparam logic [6:0] VBASE_ADDR    = 7'h7C;
   // field positions
   localparam int GCFG_ACK_LSB   = 6;
   localparam int GCFG_IVC_LSB   = 1;
   localparam int GCFG_ISRM_BIT  = 0;
   localparam int FLOW_BIT       = 4;
   localparam int LOOP_ERR_BIT   = 3;
   localparam int LOOP_MODE_LSB  = 1;
   localparam int TEST_DIV_BIT   = 7;
   localparam int IDDQ_BIT       = 0;
   localparam int ISR_RX_BIT     = 1;
   localparam int ISR_TX_BIT     = 0;
   // reset values and commands
   localparam logic [7:0] CMD_ENABLE_BOTH = 8'hE0;
   localparam logic [7:0] VECTOR_NONE     = 8'hFF;
   localparam logic [7:0] GCFG_RESET      = 8'h00;
   localparam logic [7:0] BYTE_ZERO       = 8'h00;
   localparam logic [6:0] REVISION_CODE   = 7'h05; // arbitrary value
   localparam logic [8:0] LEGACY_FIFO_DEPTH = 9'h008;
   localparam logic [8:0] FULL_FIFO_DEPTH   = 9'h100;
   localparam int DEFAULT_BAUD      = 9600;
   localparam logic [3:0] BAUD_CODE_9600 = 4'hB;
   localparam logic [3:0] DATA_BITS_8    = 4'h8;
   // ack delay in whole wait cycles for timing codes 00, 01 and 10; code 11 uses ACK_WAIT_00
   localparam logic [1:0] ACK_WAIT_00 = 2'h2;
   localparam logic [1:0] ACK_WAIT_01 = 2'h1;
   localparam logic [1:0] ACK_WAIT_10 = 2'h0;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WAIT = 3'b010,
      BUS_ACK  = 3'b100
   } duargc_bus_state_type;

   // per-channel status from the channel logic
   typedef struct packed {
      logic       flow_evt;
      logic       flow_read;
      logic       addr_own;
      logic       addr_other;
      logic       multidrop;
      logic       doze_en;
      logic       rx_err;
      logic       tx_load;
      logic [7:0] tx_char;
      logic       tx_bit_clock;
      logic       ret_valid;
      logic [7:0] ret_char;
      logic       ret_par_err;
      logic       ret_frm_err;
      logic [7:0] isr_raw;
      logic [7:0] interrupt_mask_reg;
   } duargc_chan_in_type;

   // per-channel control toward the channel logic
   typedef struct packed {
      logic       rx_en;
      logic       tx_en;
      logic       rx_load_en;
      logic [3:0] baud_code;
      logic [3:0] data_bits;
      logic       parity_en;
      logic       two_stop;
      logic       rx_int_full;
      logic       tx_int_ready;
   } duargc_chan_out_type;
endpackage : duargc_pkg

/* hw/duargc_core.sv */
/*
 global configuration and status register bank of a dual uart:
 host access timing, vector generation, flow-event and loop-check flags,
 wake/doze of the receivers, legacy defaults, test and status registers.
 assumes synchronous host strobes and per-channel status from channel logic.
*/
// Overview of operation
// - flow events reach interrupt, gated by mask bit 4
// - status bit 4 shows pending flow event
// - reset disables character recognition and its interrupt
// - own address wakes receiver, loads data
// - foreign address dozes receiver when programmed
// - reset restores legacy 9600 8N1, disabled
// - reset selects rx ready, tx empty interrupts
// - command 0xE0 enables receiver and transmitter
// - low 16 addresses legacy; higher enable extended
// - legacy reset makes FIFOs 8 bytes
// - legacy reset makes I/O ports inputs
// - config bits 7:6 set acknowledge delay
// - vector control 00 drives 0xFF
// - vector control 01/10/11 build vector
// - type field encodes rx, rx error, tx, other
// - config bit 0 masks status reads
// - loop error bit 3 set, write-1 clears
// - loop check compares returned char per edge mode
// - mismatch, parity or framing error flags interrupt
// - test bit 7 bypasses divide-by-16
// - revision bits 6:0 hard-wired, read only
// - scan bit 0 disables pin pull-ups
// - enable status reports subsystem enables
// - enhanced status reports enhanced sub-modes
`timescale 1ns/1ps
`default_nettype none
module duargc_core (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          reset_i,
   input  wire logic                          legacy_mode_reset_command_i,
   // host bus
   input  wire logic                          cs_n_i,
   input  wire logic                          rd_n_i,
   input  wire logic                          wr_n_i,
   input  wire logic                          interrupt_ack_in_n_i,
   input  wire logic [6:0]                    addr_i,
   input  wire logic [7:0]                    wdata_i,
   output logic      [7:0]                    rdata_o,
   output logic                               rdata_oe_o,
   output logic                               data_transfer_ack_n_o,
   output logic                               interrupt_request_out_n_o,
   // channels
   input  wire duargc_pkg::duargc_chan_in_type  chan_i [duargc_pkg::NUM_CH],
   output duargc_pkg::duargc_chan_out_type      chan_o [duargc_pkg::NUM_CH],
   // global status and control
   input  wire logic [7:0]                    enhanced_status_i,
   input  wire logic [15:0]                   io_dir_req_i,
   output logic [15:0]                        io_output_en_o,
   output logic [8:0]                         fifo_depth_o,
   output logic                               legacy_mode_o,
   output logic                               bypass_div16_o,
   output logic                               pullup_disable_o
);
   localparam int NC = duargc_pkg::NUM_CH;

   duargc_pkg::duargc_bus_state_type st_ff, nxt_st;
   duargc_pkg::duargc_chan_out_type  cout_ff [NC], nxt_cout [NC];
   logic [1:0] cnt_ff, nxt_cnt;
   logic [7:0] rdata_ff, nxt_rdata, gcfg_ff, nxt_gcfg, vbase_ff, nxt_vbase;
   logic [7:0] stc_ff, nxt_stc;
   logic       test_ff, nxt_test, ext_ff, nxt_ext;
   logic       ack_n_ff, nxt_ack_n, oe_ff, nxt_oe, irq_n_ff, nxt_irq_n;
   logic [15:0] ioen_ff, nxt_ioen;
   logic [3:0] feat_ff [NC], nxt_feat [NC];
   logic       flow_ff [NC], nxt_flow [NC];
   logic       lerr_ff [NC], nxt_lerr [NC];
   logic [1:0] lmode_ff [NC], nxt_lmode [NC];
   logic [7:0] txsave_ff [NC], nxt_txsave [NC];
   logic       txc_ff [NC], nxt_txc [NC];
   logic [7:0] interrupt_status_reg [NC], isr_pend [NC];
   logic       any_reset, req, start, is_wr, is_iack;
   logic [8:0] depth_ff, nxt_depth;
   logic       leg_ff, nxt_leg;

   function automatic logic [1:0] ack_wait(input logic [1:0] code);
      case (code)
         2'b01:   ack_wait = duargc_pkg::ACK_WAIT_01;
         2'b10:   ack_wait = duargc_pkg::ACK_WAIT_10;
         default: ack_wait = duargc_pkg::ACK_WAIT_00;
      endcase
   endfunction : ack_wait

   function automatic logic [1:0] int_type(input logic [7:0] p, input logic err);
      if (p[duargc_pkg::ISR_RX_BIT]) int_type = err ? 2'b11 : 2'b10;
      else if (p[duargc_pkg::ISR_TX_BIT]) int_type = 2'b01;
      else int_type = 2'b00;
   endfunction : int_type

   function automatic logic [7:0] vector(input logic [1:0] vector_control_field, input logic [7:0] base,
                                         input logic ch, input logic [1:0] ty);
      case (vector_control_field)
         2'b01:   vector = base;
         2'b10:   vector = {base[7:1], ch};
         2'b11:   vector = {base[7:3], ty, ch};
         default: vector = duargc_pkg::VECTOR_NONE;
      endcase
   endfunction : vector

   assign any_reset = reset_i || legacy_mode_reset_command_i;
   assign is_iack   = !interrupt_ack_in_n_i;
   assign req       = (!cs_n_i && (!rd_n_i || !wr_n_i)) || is_iack;
   assign start     = (st_ff == duargc_pkg::BUS_IDLE) && req;
   assign is_wr     = !cs_n_i && !wr_n_i && !is_iack;

   always_comb begin
      for (int c = 0; c < NC; c++) begin
         interrupt_status_reg[c] = chan_i[c].isr_raw;
         interrupt_status_reg[c][duargc_pkg::FLOW_BIT] = flow_ff[c];
         isr_pend[c] = interrupt_status_reg[c] & chan_i[c].interrupt_mask_reg;
      end
   end

   always_comb begin
      logic       vch;
      logic [7:0] rd;
      logic       doit;
      vch = !(|isr_pend[0]);
      rd  = duargc_pkg::BYTE_ZERO;
      doit = start && is_wr;
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_rdata = rdata_ff;
      nxt_gcfg = gcfg_ff;
      nxt_vbase = vbase_ff;
      nxt_stc = stc_ff;
      nxt_test = test_ff;
      nxt_ext = ext_ff;
      nxt_ioen = ext_ff ? io_dir_req_i : 16'h0000;
      nxt_oe = oe_ff;
      nxt_cout = cout_ff;
      nxt_feat = feat_ff;
      nxt_lerr = lerr_ff;
      nxt_lmode = lmode_ff;
      nxt_txsave = txsave_ff;
      // host cycle timing
      case (st_ff)
         duargc_pkg::BUS_IDLE: begin
            if (req) begin
               nxt_cnt = ack_wait(gcfg_ff[duargc_pkg::GCFG_ACK_LSB +: 2]);
               nxt_st  = (nxt_cnt == 2'h0) ? duargc_pkg::BUS_ACK : duargc_pkg::BUS_WAIT;
               nxt_oe  = !is_wr;
            end
         end
         duargc_pkg::BUS_WAIT: begin
            if (cnt_ff == 2'h1) nxt_st = duargc_pkg::BUS_ACK;
            else nxt_cnt = cnt_ff - 2'h1;
         end
         duargc_pkg::BUS_ACK: begin
            if (!req) begin
               nxt_st = duargc_pkg::BUS_IDLE;
               nxt_oe = 1'b0;
            end
         end
         default: nxt_st = duargc_pkg::BUS_IDLE;
      endcase
      // read mux, sampled at cycle start
      if (is_iack) begin
         rd = vector(gcfg_ff[duargc_pkg::GCFG_IVC_LSB +: 2], vbase_ff, vch,
                     int_type(isr_pend[vch], chan_i[vch].rx_err));
      end else begin
         case (addr_i)
            duargc_pkg::GCFG_ADDR:  rd = gcfg_ff;
            duargc_pkg::VBASE_ADDR: rd = vbase_ff;
            duargc_pkg::TREV_ADDR:  rd = {test_ff, duargc_pkg::REVISION_CODE};
            duargc_pkg::STC_ADDR:   rd = stc_ff;
            duargc_pkg::EOPS_ADDR:  rd = enhanced_status_i & 8'h5F;
            default: begin
               for (int c = 0; c < NC; c++) begin
                  if (addr_i == duargc_pkg::ISTAT_A_ADDR + 7'(c))
                     rd = gcfg_ff[duargc_pkg::GCFG_ISRM_BIT] ? isr_pend[c] : interrupt_status_reg[c];
                  if (addr_i == duargc_pkg::SFST_A_ADDR + 7'(c))
                     rd = {4'h0, lerr_ff[c], lmode_ff[c], 1'b0};
                  if (addr_i == duargc_pkg::SEST_A_ADDR + 7'(c))
                     rd = {2'b00, cout_ff[c].tx_en, cout_ff[c].rx_en, feat_ff[c]};
                  if (addr_i == duargc_pkg::FEAT_A_ADDR + 7'(c))
                     rd = {4'h0, feat_ff[c]};
               end
            end
         endcase
      end
      if (start && !is_wr) nxt_rdata = rd;
      if (start && !is_iack && addr_i >= duargc_pkg::LEGACY_TOP) nxt_ext = 1'b1;
      // register writes at cycle start
      if (doit && addr_i == duargc_pkg::GCFG_ADDR) nxt_gcfg = {wdata_i[7:6], 3'b000, wdata_i[2:0]};
      if (doit && addr_i == duargc_pkg::VBASE_ADDR) nxt_vbase = wdata_i;
      if (doit && addr_i == duargc_pkg::TREV_ADDR) nxt_test = wdata_i[duargc_pkg::TEST_DIV_BIT];
      if (doit && addr_i == duargc_pkg::STC_ADDR) nxt_stc = {5'h00, wdata_i[2:0]};
      for (int c = 0; c < NC; c++) begin
         nxt_txc[c] = chan_i[c].tx_bit_clock;
         nxt_cout[c].rx_load_en = cout_ff[c].rx_en;
         if (doit && addr_i == (c == 0 ? duargc_pkg::CMD_A_ADDR : duargc_pkg::CMD_B_ADDR)
             && wdata_i == duargc_pkg::CMD_ENABLE_BOTH) begin
            nxt_cout[c].rx_en = 1'b1;
            nxt_cout[c].tx_en = 1'b1;
         end
         if (chan_i[c].multidrop && chan_i[c].addr_own) begin
            nxt_cout[c].rx_en = 1'b1;
            nxt_cout[c].rx_load_en = 1'b1;
         end else if (chan_i[c].multidrop && chan_i[c].doze_en && chan_i[c].addr_other) begin
            nxt_cout[c].rx_en = 1'b0;
            nxt_cout[c].rx_load_en = 1'b0;
         end
         if (doit && addr_i == duargc_pkg::FEAT_A_ADDR + 7'(c)) nxt_feat[c] = wdata_i[3:0];
         if (doit && addr_i == duargc_pkg::SFST_A_ADDR + 7'(c)) begin
            nxt_lmode[c] = wdata_i[duargc_pkg::LOOP_MODE_LSB +: 2];
            if (wdata_i[duargc_pkg::LOOP_ERR_BIT]) nxt_lerr[c] = 1'b0;
         end
         // flow-character event, recognition must be enabled; set beats clear
         nxt_flow[c] = flow_ff[c] && !chan_i[c].flow_read;
         if (chan_i[c].flow_evt && |feat_ff[c][1:0]) nxt_flow[c] = 1'b1;
         // remote loop check
         if (chan_i[c].tx_load) nxt_txsave[c] = chan_i[c].tx_char;
         if (chan_i[c].ret_valid &&
             ((lmode_ff[c] == 2'b01 && chan_i[c].tx_bit_clock && !txc_ff[c]) ||
              (lmode_ff[c] == 2'b10 && !chan_i[c].tx_bit_clock && txc_ff[c])) &&
             (chan_i[c].ret_char != txsave_ff[c] || chan_i[c].ret_par_err ||
              chan_i[c].ret_frm_err))
            nxt_lerr[c] = 1'b1;
      end
      nxt_ack_n = (nxt_st != duargc_pkg::BUS_ACK);
      // fifo depth and legacy outputs follow nxt_ext so they switch together with it; io enables follow ext_ff, a cycle later
      nxt_depth = nxt_ext ? duargc_pkg::FULL_FIFO_DEPTH : duargc_pkg::LEGACY_FIFO_DEPTH;
      nxt_leg   = !nxt_ext;
      nxt_irq_n = !(|isr_pend[0] || |isr_pend[1] || lerr_ff[0] || lerr_ff[1]);
   end

   always_ff @(posedge clk_i) begin
      if (any_reset) begin
         st_ff    <= duargc_pkg::BUS_IDLE;
         cnt_ff   <= 2'h0;
         rdata_ff <= duargc_pkg::BYTE_ZERO;
         ack_n_ff <= 1'b1;
         oe_ff    <= 1'b0;
         irq_n_ff <= 1'b1;
         depth_ff <= duargc_pkg::LEGACY_FIFO_DEPTH;
         leg_ff   <= 1'b1;
         ext_ff   <= 1'b0;
         ioen_ff  <= 16'h0000;
         for (int c = 0; c < NC; c++) begin
            cout_ff[c].rx_en        <= 1'b0;
            cout_ff[c].tx_en        <= 1'b0;
            cout_ff[c].rx_load_en   <= 1'b0;
            cout_ff[c].baud_code    <= duargc_pkg::BAUD_CODE_9600;
            cout_ff[c].data_bits    <= duargc_pkg::DATA_BITS_8;
            cout_ff[c].parity_en    <= 1'b0;
            cout_ff[c].two_stop     <= 1'b0;
            cout_ff[c].rx_int_full  <= 1'b0;
            cout_ff[c].tx_int_ready <= 1'b0;
            feat_ff[c]   <= 4'h0;
            flow_ff[c]   <= 1'b0;
            lerr_ff[c]   <= 1'b0;
            lmode_ff[c]  <= 2'b00;
            txsave_ff[c] <= duargc_pkg::BYTE_ZERO;
            txc_ff[c]    <= 1'b0;
         end
      end else begin
         st_ff     <= nxt_st;
         cnt_ff    <= nxt_cnt;
         rdata_ff  <= nxt_rdata;
         ack_n_ff  <= nxt_ack_n;
         oe_ff     <= nxt_oe;
         irq_n_ff  <= nxt_irq_n;
         depth_ff  <= nxt_depth;
         leg_ff    <= nxt_leg;
         ext_ff    <= nxt_ext;
         ioen_ff   <= nxt_ioen;
         cout_ff   <= nxt_cout;
         feat_ff   <= nxt_feat;
         flow_ff   <= nxt_flow;
         lerr_ff   <= nxt_lerr;
         lmode_ff  <= nxt_lmode;
         txsave_ff <= nxt_txsave;
         txc_ff    <= nxt_txc;
      end
   end

   // global settings survive the legacy command, only hardware reset clears them
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         gcfg_ff  <= duargc_pkg::GCFG_RESET;
         vbase_ff <= duargc_pkg::BYTE_ZERO;
         stc_ff   <= duargc_pkg::BYTE_ZERO;
         test_ff  <= 1'b0;
      end else begin
         gcfg_ff  <= nxt_gcfg;
         vbase_ff <= nxt_vbase;
         stc_ff   <= nxt_stc;
         test_ff  <= nxt_test;
      end
   end

   assign rdata_o                   = rdata_ff;
   assign rdata_oe_o                = oe_ff;
   assign data_transfer_ack_n_o     = ack_n_ff;
   assign interrupt_request_out_n_o = irq_n_ff;
   assign chan_o                    = cout_ff;
   assign io_output_en_o            = ioen_ff;
   assign fifo_depth_o              = depth_ff;
   assign legacy_mode_o             = leg_ff;
   assign bypass_div16_o            = test_ff;
   assign pullup_disable_o          = stc_ff[duargc_pkg::IDDQ_BIT];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   flow_irq_gate_a: assert property (
      flow_ff[0] && chan_i[0].interrupt_mask_reg[duargc_pkg::FLOW_BIT] && !legacy_mode_reset_command_i
      |=> !interrupt_request_out_n_o)
      else $error("masked-in flow event did not raise interrupt");
   flow_status_set_a: assert property (
      chan_i[0].flow_evt && feat_ff[0][0] && !legacy_mode_reset_command_i |=> interrupt_status_reg[0][4])
      else $error("flow event not shown in status bit 4");
   reset_rec_off_a: assert property (
      legacy_mode_reset_command_i |=> feat_ff[0] == 4'h0 && !flow_ff[0])
      else $error("recognition not disabled by reset");
   addr_wake_a: assert property (
      chan_i[1].multidrop && chan_i[1].addr_own && !legacy_mode_reset_command_i
      |=> chan_o[1].rx_en && chan_o[1].rx_load_en)
      else $error("own address did not wake receiver");
   ack_slow_a: assert property (
      start && gcfg_ff[7:6] == 2'b00 |=> data_transfer_ack_n_o [*2] ##1 !data_transfer_ack_n_o)
      else $error("ack delay for code 00 wrong");
   ack_fast_a: assert property (
      start && gcfg_ff[7:6] == 2'b10 |=> !data_transfer_ack_n_o)
      else $error("ack delay for code 10 wrong");
   vector_none_a: assert property (
      start && is_iack && gcfg_ff[2:1] == 2'b00 |=> rdata_o == 8'hFF && rdata_oe_o)
      else $error("no-vector cycle did not drive ff");
   isr_mask_a: assert property (
      start && !is_wr && !is_iack && addr_i == duargc_pkg::ISTAT_A_ADDR && gcfg_ff[0]
      |=> (rdata_o & ~$past(chan_i[0].interrupt_mask_reg)) == 8'h00)
      else $error("masked status read shows unmasked bit");
   loop_clear_a: assert property (
      lerr_ff[0] && start && is_wr && addr_i == duargc_pkg::SFST_A_ADDR && wdata_i[3]
      && !chan_i[0].ret_valid && !legacy_mode_reset_command_i |=> !lerr_ff[0])
      else $error("loop error not cleared by write one");
   rev_code_a: assert property (
      start && !is_wr && !is_iack && addr_i == duargc_pkg::TREV_ADDR |=> rdata_o[6:0] == 7'h05)
      else $error("revision code wrong");
   ack_mid_a: assert property (
      start && gcfg_ff[7:6] == 2'b01 |=> data_transfer_ack_n_o ##1 !data_transfer_ack_n_o)
      else $error("ack delay for code 01 wrong");
   ext_enter_a: assert property (
      start && !is_iack && addr_i >= duargc_pkg::LEGACY_TOP && !legacy_mode_reset_command_i |=> !legacy_mode_o)
      else $error("extended access kept legacy mode");
   io_input_a: assert property (
      legacy_mode_o |-> io_output_en_o == 16'h0000)
      else $error("io driven in legacy mode");
   cmd_enable_a: assert property (
      start && is_wr && addr_i == duargc_pkg::CMD_A_ADDR && wdata_i == duargc_pkg::CMD_ENABLE_BOTH
      && !chan_i[0].multidrop && !legacy_mode_reset_command_i |=> chan_o[0].rx_en && chan_o[0].tx_en)
      else $error("enable command ignored");
   doze_a: assert property (
      chan_i[1].multidrop && chan_i[1].doze_en && chan_i[1].addr_other && !chan_i[1].addr_own
      && !legacy_mode_reset_command_i |=> !chan_o[1].rx_en)
      else $error("foreign address did not doze receiver");
   loop_fall_a: assert property (
      chan_i[0].ret_valid && lmode_ff[0] == 2'b10 && txc_ff[0] && !chan_i[0].tx_bit_clock
      && chan_i[0].ret_char != txsave_ff[0] && !legacy_mode_reset_command_i |=> lerr_ff[0])
      else $error("falling-edge loop mismatch missed");
   cov_iack_c: cover property (start && is_iack && gcfg_ff[2:1] == 2'b11);
   cov_doze_c: cover property (chan_i[1].multidrop && chan_i[1].addr_other);
   cov_loop_c: cover property (!lerr_ff[0] ##1 lerr_ff[0]);
   cov_wake_c: cover property (chan_i[0].multidrop && chan_i[0].addr_own);
endmodule : duargc_core
`default_nettype wire

/* test/duargc_host.sv */
/*
 host processor model on the parallel register bus of the config block.
 assumes synchronous strobes sampled on the rising edge of clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module duargc_host (
   // clock
   input  wire logic       clk_i,
   // answer from the device
   input  wire logic       ack_n_i,
   input  wire logic [7:0] rdata_i,
   // request toward the device
   output logic            cs_n_o = 1'b1,
   output logic            rd_n_o = 1'b1,
   output logic            wr_n_o = 1'b1,
   output logic            iack_n_o = 1'b1,
   output logic [6:0]      addr_o = 7'h00,
   output logic [7:0]      wdata_o = 8'h00
);
   // one access: strobes held until ack sampled low, then released
   task automatic acc(input logic w, input logic ia, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q, output int lat);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      cs_n_o <= ia;
      rd_n_o <= w | ia;
      wr_n_o <= ~w | ia;
      iack_n_o <= ~ia;
      lat = 0;
      @(posedge clk_i);
      do begin
         @(posedge clk_i);
         lat++;
      end while (ack_n_i !== 1'b0 && lat < 20);
      q = rdata_i;
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      iack_n_o <= 1'b1;
      while (ack_n_i !== 1'b1) @(posedge clk_i);
      // released bus shows no stale value
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask : acc
endmodule : duargc_host
`default_nettype wire

/* test/duargc_core_test.sv */
/*
 self-checking bench of the global configuration and status block.
 assumes the host model in duargc_host and one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module duargc_core_test;
   logic clk_i = 1'b0, reset_i = 1'b1, leg_cmd = 1'b0;
   logic cs_n, rd_n, wr_n, iack_n, oe, ack_n, irq_n, legacy, byp, pud;
   logic [6:0] addr;
   logic [7:0] wdata, rdata, q;
   logic [15:0] io_req = 16'hA5C3, io_en;
   logic [8:0] depth;
   int lat, mismatches = 0, cmp_count = 0;
   duargc_pkg::duargc_chan_in_type  ch [duargc_pkg::NUM_CH] = '{default: '0};
   duargc_pkg::duargc_chan_out_type co [duargc_pkg::NUM_CH];
   initial forever #5 clk_i = ~clk_i;
   duargc_host u_host (.clk_i(clk_i), .ack_n_i(ack_n), .rdata_i(rdata), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .iack_n_o(iack_n), .addr_o(addr), .wdata_o(wdata));
   duargc_core u_dut (.clk_i(clk_i), .reset_i(reset_i), .legacy_mode_reset_command_i(leg_cmd),
      .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .interrupt_ack_in_n_i(iack_n), .addr_i(addr),
      .wdata_i(wdata), .rdata_o(rdata), .rdata_oe_o(oe), .data_transfer_ack_n_o(ack_n),
      .interrupt_request_out_n_o(irq_n), .chan_i(ch), .chan_o(co), .enhanced_status_i(8'h00),
      .io_dir_req_i(io_req), .io_output_en_o(io_en), .fifo_depth_o(depth), .legacy_mode_o(legacy),
      .bypass_div16_o(byp), .pullup_disable_o(pud));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_host.acc(1'b1, 1'b0, a, d, q, lat);
   endtask : wr
   task automatic rd(input logic [6:0] a);
      u_host.acc(1'b0, 1'b0, a, 8'h00, q, lat);
   endtask : rd
   task automatic t_reset;
      chk("legacy", 16'h0001, legacy);
      chk("depth", duargc_pkg::LEGACY_FIFO_DEPTH, depth);
      chk("baud", duargc_pkg::BAUD_CODE_9600, co[0].baud_code);
      chk("bits", duargc_pkg::DATA_BITS_8, co[1].data_bits);
      chk("enables", 16'h0000, {co[0].rx_en, co[0].tx_en, co[0].parity_en, co[0].two_stop});
      chk("int_src", 16'h0000, {co[0].rx_int_full, co[0].tx_int_ready});
      chk("io_en", 16'h0000, io_en);
      chk("irq", 16'h0001, irq_n);
      chk("bypass", 16'h0000, byp);
      wr(duargc_pkg::CMD_A_ADDR, duargc_pkg::CMD_ENABLE_BOTH);
      chk("rxtx_on", 16'h0003, {co[0].rx_en, co[0].tx_en});
      chk("legacy2", 16'h0001, legacy);
      rd(duargc_pkg::SFST_A_ADDR);
      chk("special_feature_status", 16'h0000, q);
      chk("ext", duargc_pkg::FULL_FIFO_DEPTH, {legacy, depth});
      chk("io_ext", io_req, io_en);
      @(posedge clk_i) leg_cmd <= 1'b1;
      @(posedge clk_i) leg_cmd <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("leg_cmd", {6'h00, 1'b1, duargc_pkg::LEGACY_FIFO_DEPTH}, {legacy, depth});
      chk("leg_io", 16'h0000, io_en);
      chk("leg_rx", 16'h0000, co[0].rx_en);
   endtask : t_reset
   task automatic t_test;
      rd(duargc_pkg::TREV_ADDR);
      chk("trev", {1'b0, duargc_pkg::REVISION_CODE}, q);
      wr(duargc_pkg::TREV_ADDR, 8'hFF);
      rd(duargc_pkg::TREV_ADDR);
      chk("trev_w", {1'b1, duargc_pkg::REVISION_CODE}, q);
      chk("bypass", 16'h0001, byp);
      wr(duargc_pkg::STC_ADDR, 8'h01);
      chk("pullup", 16'h0001, pud);
      wr(duargc_pkg::TREV_ADDR, 8'h00);
   endtask : t_test
   task automatic t_ack;
      int e [4] = '{3, 2, 1, 3};
      for (int i = 0; i < 4; i++) begin
         wr(duargc_pkg::GCFG_ADDR, {i[1:0], 6'h3F});
         rd(duargc_pkg::GCFG_ADDR);
         chk("gcfg", {i[1:0], 6'h07}, q);
         chk("ack_lat", e[i], lat);
      end
   endtask : t_ack
   task automatic t_vec;
      logic [7:0] e [4] = '{8'hFF, 8'hA5, 8'hA5, 8'hA3};
      wr(duargc_pkg::VBASE_ADDR, 8'hA5);
      ch[1].isr_raw <= 8'h01;
      ch[1].interrupt_mask_reg <= 8'h01;
      repeat (3) @(posedge clk_i);
      chk("irq_tx", 16'h0000, irq_n);
      for (int i = 0; i < 4; i++) begin
         wr(duargc_pkg::GCFG_ADDR, {5'h10, i[1:0], 1'b0});
         u_host.acc(1'b0, 1'b1, 7'h00, 8'h00, q, lat);
         chk("vector", e[i], q);
      end
      ch[1].interrupt_mask_reg <= 8'h00;
      ch[0].isr_raw <= 8'h02;
      ch[0].interrupt_mask_reg <= 8'h02;
      ch[0].rx_err <= 1'b1;
      u_host.acc(1'b0, 1'b1, 7'h00, 8'h00, q, lat);
      chk("vec_rxerr", 16'h00A6, q);
      ch[0].rx_err <= 1'b0;
      u_host.acc(1'b0, 1'b1, 7'h00, 8'h00, q, lat);
      chk("vec_rx", 16'h00A4, q);
   endtask : t_vec
   task automatic t_isr;
      ch[0].isr_raw <= 8'h03;
      wr(duargc_pkg::GCFG_ADDR, 8'h80);
      rd(duargc_pkg::ISTAT_A_ADDR);
      chk("isr_raw", 16'h0003, q);
      wr(duargc_pkg::GCFG_ADDR, 8'h81);
      rd(duargc_pkg::ISTAT_A_ADDR);
      chk("isr_mask", 16'h0002, q);
      ch[0].isr_raw <= 8'h00;
      ch[0].interrupt_mask_reg <= 8'h10;
      wr(duargc_pkg::FEAT_A_ADDR, 8'h03);
      @(posedge clk_i) ch[0].flow_evt <= 1'b1;
      @(posedge clk_i) ch[0].flow_evt <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("irq_flow", 16'h0000, irq_n);
      rd(duargc_pkg::ISTAT_A_ADDR);
      chk("isr4", 16'h0001, q[4]);
      ch[0].interrupt_mask_reg <= 8'h00;
      repeat (3) @(posedge clk_i);
      chk("irq_masked", 16'h0001, irq_n);
      @(posedge clk_i) ch[0].flow_read <= 1'b1;
      @(posedge clk_i) ch[0].flow_read <= 1'b0;
      ch[0].interrupt_mask_reg <= 8'h10;
      rd(duargc_pkg::ISTAT_A_ADDR);
      chk("isr4_clr", 16'h0000, q[4]);
   endtask : t_isr
   task automatic t_loop;
      wr(duargc_pkg::SFST_A_ADDR, 8'h02);
      ch[0].tx_char <= 8'h55;
      ch[0].ret_char <= 8'h54;
      @(posedge clk_i) ch[0].tx_load <= 1'b1;
      @(posedge clk_i) ch[0].tx_load <= 1'b0;
      ch[0].ret_valid <= 1'b1;
      @(posedge clk_i) ch[0].tx_bit_clock <= 1'b1;
      repeat (4) @(posedge clk_i);
      ch[0].ret_valid <= 1'b0;
      chk("irq_loop", 16'h0000, irq_n);
      rd(duargc_pkg::SFST_A_ADDR);
      chk("loop_err", 16'h000A, q);
      wr(duargc_pkg::SFST_A_ADDR, 8'h0A);
      rd(duargc_pkg::SFST_A_ADDR);
      chk("loop_clr", 16'h0002, q);
      wr(duargc_pkg::SFST_A_ADDR, 8'h04);
      ch[0].ret_valid <= 1'b1;
      @(posedge clk_i) ch[0].tx_bit_clock <= 1'b0;
      repeat (2) @(posedge clk_i);
      ch[0].ret_valid <= 1'b0;
      rd(duargc_pkg::SFST_A_ADDR);
      chk("loop_fall", 16'h000C, q);
   endtask : t_loop
   task automatic t_wake;
      ch[1].multidrop <= 1'b1;
      ch[1].doze_en <= 1'b1;
      @(posedge clk_i) ch[1].addr_own <= 1'b1;
      @(posedge clk_i) ch[1].addr_own <= 1'b0;
      @(posedge clk_i) chk("wake", 16'h0001, co[1].rx_en);
      ch[1].addr_other <= 1'b1;
      @(posedge clk_i) ch[1].addr_other <= 1'b0;
      @(posedge clk_i) chk("doze", 16'h0000, co[1].rx_en);
   endtask : t_wake
   task automatic summarize;
      if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      #200us;
      mismatches++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_test();
      t_ack();
      t_vec();
      t_isr();
      t_loop();
      t_wake();
      summarize();
   end
endmodule : duargc_core_test
`default_nettype wire
